// File: dv/four_stage_piso_sipo_shift_register_tb_top.sv
// Self-checking bench for the four-stage shift register and its register slave
`include "shreg4_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module four_stage_piso_sipo_shift_register_tb_top;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk = 1'h0;
	logic        rst = 1'h0;
	logic        tsel = 1'h1;
	logic [6:0]  nx = 7'h00;
	wire logic   load, sj, skn;
	wire logic [3:0] pd, dout;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int          fail_count = 0;
	int          n_compared = 0;
	logic [3:0]  st;                 // Model of the stage bits
	logic        run;                // Model of the run bit
	logic [31:0] seed = 32'h0001_7ba3; // Random source state, 97187
	logic [31:0] rd;
	logic [1:0]  rs;

	// Clock of 10 ns
	always #5 clk = ~clk;

	// ---------------------------------------------------------------
	// Instances
	// ---------------------------------------------------------------
	shreg4_sys_pins u_shreg4_sys_pins (.clk(clk), .nx(nx), .load_sel(load), .ser_j(sj),
		.ser_k_n(skn), .par_d(pd));
	shreg4_core u_shreg4_core (.CLK(clk), .SYS_RST(rst), .LOAD_SEL(load), .TRUE_SEL(tsel),
		.SER_J(sj), .SER_K_N(skn), .PAR_D(pd), .DATA_OUT(dout),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	// Shift-register random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Verdict and end of run
	task automatic end_of_test;
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Word comparison; an unknown bit matches only an unknown bit
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
		end
	endtask

	// Model step for the coming rising edge, from the pins now applied
	task automatic upd;
		logic jk;
		case ({sj, skn})
			2'h0: jk = 1'h0;
			2'h3: jk = 1'h1;
			2'h1: jk = st[0];    // Hold
			default: jk = ~st[0]; // Toggle
		endcase
		if (run) st = load ? pd : {st[2:0], jk};
	endtask

	// One cycle: check, flip polarity off-edge, check again, pick next pins
	task automatic cyc(input logic [7:0] p);
		@(negedge clk);
		cmp({28'h0, dout}, {28'h0, tsel ? st : ~st});
		tsel = p[7];
		#1;
		cmp({28'h0, dout}, {28'h0, tsel ? st : ~st});
		upd();
		nx = p[6:0];
	endtask

	// Register write: address and data together, wait for the response
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic seen;
		seen = 1'h0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int k = 0; k < 50; k++) begin
			@(posedge clk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
			if (bvalid === 1'h1) begin
				seen = 1'h1;
				break;
			end
		end
		r = bresp;
		bready <= 1'h0;
		// A response that never comes is a failure, not a silent pass
		if (!seen) begin
			fail_count++;
			$display("[ERR] %0t write response missing", $time);
		end
	endtask

	// Register read: wait for the data
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic seen;
		seen = 1'h0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int k = 0; k < 50; k++) begin
			@(posedge clk);
			if (arready === 1'h1) arvalid <= 1'h0;
			if (rvalid === 1'h1) begin
				seen = 1'h1;
				break;
			end
		end
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		// Read data that never comes is a failure, not a silent pass
		if (!seen) begin
			fail_count++;
			$display("[ERR] %0t read data missing", $time);
		end
	endtask

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end

	initial begin
		st = 4'h0;
		run = 1'h1;
		// A real rising edge before the first clock, so the flops clear at once
		#1 rst = 1'h1;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		// Random loads, shifts and all four J/K codes
		for (int i = 0; i < 200; i++) begin
			seed = lfsr(seed);
			cyc(seed[7:0]);
		end
		// Reset in mid-cycle acts with no edge
		#2 rst = 1'h1;
		#1 cmp({28'h0, dout}, {28'h0, tsel ? 4'h0 : 4'hf});
		st = 4'h0;
		@(negedge clk) rst = 1'h0;
		upd();
		// Settle on a steady parallel load, then stop the stages
		repeat (2) cyc(8'hc5);
		axi_wr(`SHREG4_OFS_CTRL, 32'h0, rs);
		cmp({30'h0, rs}, {30'h0, `SHREG4_RESP_OKAY});
		run = 1'h0;
		repeat (3) cyc(8'hca);
		axi_rd(`SHREG4_OFS_STAT, rd, rs);
		cmp(rd, {20'h0, tsel ? st : ~st, 4'h0, st});
		cmp({30'h0, rs}, {30'h0, `SHREG4_RESP_OKAY});
		axi_rd(`SHREG4_OFS_CTRL, rd, rs);
		cmp({rd[31:0]}, 32'h0);
		// Read-only and unmapped places
		axi_wr(`SHREG4_OFS_STAT, 32'hffff_ffff, rs);
		cmp({30'h0, rs}, {30'h0, `SHREG4_RESP_OKAY});
		axi_wr(8'h08, 32'h1, rs);
		cmp({30'h0, rs}, {30'h0, `SHREG4_RESP_SLVERR});
		axi_rd(8'h10, rd, rs);
		cmp({rd[29:0], rs}, {30'h0, `SHREG4_RESP_SLVERR});
		// Restart: the held pins load at once
		axi_wr(`SHREG4_OFS_CTRL, 32'h1, rs);
		run = 1'h1;
		st = 4'ha;
		for (int i = 0; i < 20; i++) begin
			seed = lfsr(seed);
			cyc(seed[7:0]);
		end
		end_of_test();
	end
endmodule // four_stage_piso_sipo_shift_register_tb_top
`default_nettype wire

// File: dv/shreg4_sys_pins.sv
// Model of the system logic that drives the shift register's data and mode pins
`timescale 1ns/10ps
`default_nettype none

module shreg4_sys_pins (
	// Clock
	input  wire logic       clk,
	// Requested levels {load, j, k_n, par[3:0]}
	input  wire logic [6:0] nx,
	// Pins toward the register
	output logic            load_sel,
	output logic            ser_j,
	output logic            ser_k_n,
	output logic [3:0]      par_d
);
	// Pins move just after a rising edge, so they are steady at the next one
	// They are unknown only until the first edge, well inside reset
	always @(posedge clk) begin
		{load_sel, ser_j, ser_k_n, par_d} <= nx;
	end
endmodule // shreg4_sys_pins
`default_nettype wire

// File: hw/shreg4_consts.svh
// Constants for the four-stage shift register: offsets, fields, reset values
`ifndef SHREG4_CONSTS_SVH
`define SHREG4_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SHREG4_OFS_CTRL      8'h00
`define SHREG4_OFS_STAT      8'h04

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define SHREG4_CTRL_RUN_BIT  0
`define SHREG4_CTRL_RST      32'h0000_0001

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SHREG4_STAT_STG_LSB  0
`define SHREG4_STAT_OUT_LSB  8

// ----------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------
`define SHREG4_RESP_OKAY     2'h0
`define SHREG4_RESP_SLVERR   2'h2

`endif

// File: hw/shreg4_core.sv
// Four-stage parallel/serial shift register with JK entry and register slave
//
// Notes on behaviour
// [RQ1] Serial mode: stages two to four chain
// [RQ2] Load-select high: all stages load parallel
// [RQ3] Parallel entry only while load-select high
// [RQ4] Stages change only on rising clock
// [RQ5] Polarity high: outputs show stored bits
// [RQ6] Polarity low: outputs show complements
// [RQ7] Polarity acts at once, no clock
// [RQ8] First stage uses JK logic serially
// [RQ9] Tied J and K: plain D stage
// [RQ10] Reset clears all stages asynchronously
// [RQ11] Stages hold contents while clock stopped
// [RQ12] K active low: load, hold, toggle
// [RQ13] Reset clears stages to zero
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`include "shreg4_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module shreg4_core #(
	parameter int STAGES = 4 // Register length
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	// Data and mode pins to and from surrounding logic
	input  wire logic              LOAD_SEL,
	input  wire logic              TRUE_SEL,
	input  wire logic              SER_J,
	input  wire logic              SER_K_N,
	input  wire logic [STAGES-1:0] PAR_D,
	output logic      [STAGES-1:0] DATA_OUT,
	// AXI4-Lite write address
	input  wire logic [7:0]        S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// AXI4-Lite read address
	input  wire logic [7:0]        S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The status word holds stages and outputs in two byte fields
	if (STAGES < 2 || STAGES > 8) begin : g_bad_len
		$error("STAGES must lie between 2 and 8");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [STAGES-1:0]     stage;       // Stored bits, stage one is bit 0
	// A net, so that every stage bit has exactly one continuous driver
	wire logic [STAGES-1:0] next_stage; // Value taken at the next edge
	logic                  run;         // Software clock gate; low freezes stages
	shreg4_pkg::mode_e     mode;        // Decoded load-select
	shreg4_pkg::wr_state_e wr_state;    // Write channel progress
	logic                  aw_held;     // Write address taken
	logic                  w_held;      // Write data taken
	logic [7:0]            aw_addr;     // Captured write address
	logic [31:0]           w_data;      // Captured write data
	logic [3:0]            w_strb;      // Captured byte enables

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// JK entry with K active low: 00 clear, 11 set, 01 hold, 10 toggle
	function automatic logic jk_next(input logic j, input logic k_n, input logic q);
		case ({j, k_n})
			2'h0:    jk_next = 1'b0;
			2'h3:    jk_next = 1'b1;
			2'h1:    jk_next = q;
			2'h2:    jk_next = ~q;
			default: jk_next = q;
		endcase
	endfunction

	// Register selection, shared by the read and write paths
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
		is_reg = (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Stage datapath
	// ----------------------------------------------------------------
	assign mode = LOAD_SEL ? shreg4_pkg::MODE_PARALLEL : shreg4_pkg::MODE_SERIAL;

	// First stage: parallel bit or JK result
	assign next_stage[0] = (mode == shreg4_pkg::MODE_PARALLEL) ? PAR_D[0] : // [RQ2] [RQ3]
	                       jk_next(SER_J, SER_K_N, stage[0]);                // [RQ8] [RQ9] [RQ12]

	// Later stages: parallel bit or previous stage
	// One assign per bit keeps each slice with a single driver
	for (genvar i = 1; i < STAGES; i++) begin : g_chain
		assign next_stage[i] = (mode == shreg4_pkg::MODE_PARALLEL) ? PAR_D[i] : // [RQ2] [RQ3]
		                       stage[i-1];                                        // [RQ1]
	end

	// Stage flip-flops; run low stands in for a stopped clock
	always_ff @(posedge CLK or posedge SYS_RST) begin // [RQ4]
		if (SYS_RST) begin
			stage <= '0;                       // [RQ10] [RQ13]
		end else if (run) begin
			stage <= next_stage;
		end else begin
			stage <= stage;                    // [RQ11]
		end
	end

	// Polarity is applied after the flops so it needs no edge
	assign DATA_OUT = TRUE_SEL ? stage : ~stage; // [RQ5] [RQ6] [RQ7]

	// ----------------------------------------------------------------
	// Register slave: write path
	// ----------------------------------------------------------------
	// Address and data are taken in either order; response follows both
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_state      <= shreg4_pkg::WR_COLLECT;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `SHREG4_RESP_OKAY;
		end else begin
			case (wr_state)
				shreg4_pkg::WR_COLLECT: begin
					// Ready is raised one cycle, then dropped on the handshake
					if (S_AXI_AWVALID && S_AXI_AWREADY) begin
						aw_held       <= 1'b1;
						aw_addr       <= S_AXI_AWADDR;
						S_AXI_AWREADY <= 1'b0;
					end else begin
						S_AXI_AWREADY <= !aw_held && S_AXI_AWVALID;
					end
					if (S_AXI_WVALID && S_AXI_WREADY) begin
						w_held       <= 1'b1;
						w_data       <= S_AXI_WDATA;
						w_strb       <= S_AXI_WSTRB;
						S_AXI_WREADY <= 1'b0;
					end else begin
						S_AXI_WREADY <= !w_held && S_AXI_WVALID;
					end
					if (aw_held && w_held) begin
						S_AXI_BVALID <= 1'b1;
						S_AXI_BRESP  <= (is_reg(aw_addr, `SHREG4_OFS_CTRL) ||
						                 is_reg(aw_addr, `SHREG4_OFS_STAT)) ?
						                `SHREG4_RESP_OKAY : `SHREG4_RESP_SLVERR;
						wr_state     <= shreg4_pkg::WR_RESPOND;
					end
				end
				shreg4_pkg::WR_RESPOND: begin
					if (S_AXI_BREADY) begin
						S_AXI_BVALID <= 1'b0;
						aw_held      <= 1'b0;
						w_held       <= 1'b0;
						wr_state     <= shreg4_pkg::WR_COLLECT;
					end
				end
				default: begin
					wr_state <= shreg4_pkg::WR_COLLECT;
				end
			endcase
		end
	end

	// Control register: only the run bit is writable, status is read-only
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			// Only the run bit of the reset word is kept
			run <= 1'(`SHREG4_CTRL_RST >> `SHREG4_CTRL_RUN_BIT);
		end else if (wr_state == shreg4_pkg::WR_COLLECT && aw_held && w_held &&
		             is_reg(aw_addr, `SHREG4_OFS_CTRL) && w_strb[0]) begin
			run <= w_data[`SHREG4_CTRL_RUN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Register slave: read path
	// ----------------------------------------------------------------
	// One read at a time; data appears the cycle after the address
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= `SHREG4_RESP_OKAY;
		end else if (S_AXI_RVALID) begin
			if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RRESP   <= `SHREG4_RESP_OKAY;
			S_AXI_RDATA   <= 32'h0000_0000;
			if (is_reg(S_AXI_ARADDR, `SHREG4_OFS_CTRL)) begin
				S_AXI_RDATA[`SHREG4_CTRL_RUN_BIT] <= run;
			end else if (is_reg(S_AXI_ARADDR, `SHREG4_OFS_STAT)) begin
				// Stored bits and the pin view side by side
				S_AXI_RDATA[`SHREG4_STAT_STG_LSB +: STAGES] <= stage;
				S_AXI_RDATA[`SHREG4_STAT_OUT_LSB +: STAGES] <= DATA_OUT;
			end else begin
				S_AXI_RRESP <= `SHREG4_RESP_SLVERR; // Unmapped reads return zero
			end
		end else begin
			S_AXI_ARREADY <= S_AXI_ARVALID;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// A clocked serial step and a clocked parallel step
	sequence s_serial_step;
		run && !LOAD_SEL;
	endsequence

	sequence s_parallel_step;
		run && LOAD_SEL;
	endsequence

	for (genvar i = 1; i < STAGES; i++) begin : g_chk_chain
		a_chain_shift: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ1]
			s_serial_step |=> stage[i] == $past(stage[i-1]))
			else $error("Serial chain stage did not take previous stage");
	end

	a_parallel_load: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ2]
		s_parallel_step |=> stage == $past(PAR_D))
		else $error("Parallel load did not capture data pins");

	// Tied J/K picks a bit opposite to the parallel pin, so a leak would show
	a_serial_no_load: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ3]
		s_serial_step ##0 (SER_J == SER_K_N) ##0 (PAR_D[0] != SER_J)
		|=> stage[0] != $past(PAR_D[0]))
		else $error("Parallel data entered in serial mode");

	a_jk_first_stage: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ12]
		s_serial_step ##0 (SER_J && !SER_K_N) |=> stage[0] != $past(stage[0]))
		else $error("JK toggle did not invert first stage");

	a_jk_hold_stage: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ8]
		s_serial_step ##0 (!SER_J && SER_K_N) |=> $stable(stage[0]))
		else $error("JK hold changed first stage");

	a_tied_jk_d: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ9]
		s_serial_step ##0 (SER_J == SER_K_N) |=> stage[0] == $past(SER_J))
		else $error("Tied JK did not act as D stage");

	a_frozen_hold: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ11]
		!run [*2] |-> $stable(stage))
		else $error("Stages changed while frozen");

	a_true_view: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ5]
		TRUE_SEL |-> (DATA_OUT ^ stage) == '0)
		else $error("True outputs differ from stages");

	a_compl_view: assert property (@(posedge CLK) disable iff (SYS_RST) // [RQ6]
		!TRUE_SEL |-> (DATA_OUT ^ stage) == '1)
		else $error("Complement outputs differ from stages");

	a_reset_clear: assert property (@(posedge CLK) // [RQ10]
		SYS_RST |-> stage == '0 && DATA_OUT == (TRUE_SEL ? '0 : '1))
		else $error("Reset did not clear stages");

	a_write_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
		(aw_held && w_held && !S_AXI_BVALID) |=> S_AXI_BVALID)
		else $error("Write response late");

	// The response is withdrawn right after the master takes it
	a_write_release: assert property (@(posedge CLK) disable iff (SYS_RST)
		(S_AXI_BVALID && S_AXI_BREADY) |=> !S_AXI_BVALID)
		else $error("Write response not withdrawn");

	// Read data follows the address handshake by one cycle
	a_read_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
		(S_AXI_ARVALID && S_AXI_ARREADY && !S_AXI_RVALID) |=> S_AXI_RVALID)
		else $error("Read data late");

	// Read data is withdrawn right after the master takes it
	a_read_release: assert property (@(posedge CLK) disable iff (SYS_RST)
		(S_AXI_RVALID && S_AXI_RREADY) |=> !S_AXI_RVALID)
		else $error("Read data not withdrawn");

endmodule // shreg4_core

`default_nettype wire

// File: hw/shreg4_pkg.sv
// Types shared by the four-stage shift register design
package shreg4_pkg;

	// Transfer mode chosen by the load-select pin
	typedef enum logic {
		MODE_SERIAL,
		MODE_PARALLEL
	} mode_e;

	// Write channel progress of the register slave
	typedef enum logic [1:0] {
		WR_COLLECT,
		WR_RESPOND
	} wr_state_e;

endpackage
